// File: common/ivpu_pkg.sv
// Constants for the interrupt vector and priority unit
package ivpu_pkg;
	// ==========================================================
	// Bus register offsets
	localparam logic [7:0] IVPU_OFS_CTRL2 = 8'h00;
	localparam logic [7:0] IVPU_OFS_FLAGS2 = 8'h04;
	localparam logic [7:0] IVPU_OFS_PRIO_CN = 8'h08;
	localparam logic [7:0] IVPU_OFS_PRIO_ENC = 8'h0C;
	localparam logic [7:0] IVPU_OFS_PRIO_GRP2 = 8'h10;
	localparam logic [7:0] IVPU_OFS_FLAGS_AUX = 8'h14;
	localparam logic [7:0] IVPU_OFS_VEC_IDX = 8'h18;
	localparam logic [7:0] IVPU_OFS_VEC_DATA = 8'h1C;
	localparam logic [7:0] IVPU_OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] IVPU_OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] IVPU_OFS_CORE_STAT = 8'h28;
	// ==========================================================
	// Field positions and masks
	localparam int unsigned IVPU_ALT_BIT = 15;
	localparam logic [15:0] IVPU_FLAGS2_MASK = 16'h601F;
	localparam logic [15:0] IVPU_AUX_MASK = 16'h180F;
	localparam logic [15:0] IVPU_PRIO_CN_MASK = 16'h7777;
	localparam logic [15:0] IVPU_PRIO_ENC_MASK = 16'h0770;
	localparam logic [31:0] IVPU_PRIO_GRP2_MASK = 32'h07777777;
	// ==========================================================
	// Sources, traps and vector table geometry
	localparam int unsigned IVPU_SRC_N = 13;
	localparam int unsigned IVPU_TRAP_N = 5;
	localparam int unsigned IVPU_ENTRIES = 18;
	localparam int unsigned IVPU_TBL_WORDS = 36;
	localparam int unsigned IVPU_EV_N = 3;
	localparam logic [6:0] IVPU_TRAP_SLOTS = 7'h08;
	localparam logic [23:0] IVPU_IVT_BASE = 24'h000004;
	localparam logic [23:0] IVPU_IVT_LEN = 24'h00007E;
	localparam logic [23:0] IVPU_BOOT_ADDR = 24'h000000;
	localparam logic [2:0] IVPU_PRIO_RST = 3'h4;
	localparam logic [2:0] IVPU_PRIO_OFF = 3'h0;
	localparam logic [3:0] IVPU_TRAP_LEVEL = 4'h8;
	// Flag home: 1 = request_flags_2, 0 = auxiliary flag register
	localparam bit IVPU_FLAG_IN_F2 [IVPU_SRC_N] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 0, 0};
	localparam int unsigned IVPU_FLAG_POS [IVPU_SRC_N] = '{0, 1, 2, 3, 0, 1, 2, 3, 4, 13, 14, 11, 12};
	// Priority home: 0 = cn/cmp/i2c, 1 = encoder/pwm, 2 = group 2
	localparam int unsigned IVPU_PRIO_REG [IVPU_SRC_N] = '{0, 0, 0, 0, 2, 2, 2, 2, 2, 2, 2, 1, 1};
	localparam int unsigned IVPU_PRIO_LSB [IVPU_SRC_N] = '{12, 8, 4, 0, 0, 4, 8, 12, 16, 20, 24, 8, 4};
	localparam bit IVPU_IS_CAN [IVPU_SRC_N] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0};
	// Sticky event bits
	localparam int unsigned IVPU_EV_TRAP = 0;
	localparam int unsigned IVPU_EV_ACK = 1;
	localparam int unsigned IVPU_EV_DIS = 2;
endpackage : ivpu_pkg

// File: rtl/ivpu_top.sv
// Interrupt vector and priority unit with AHB-Lite register slave
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module ivpu_top
	import ivpu_pkg::*;
#(
	parameter bit HAS_CAN = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata_ff,
	output logic hreadyout_ff,
	output logic hresp_ff,
	input wire logic [12:0] src_req,
	input wire logic [4:0] trap_req,
	input wire logic [3:0] cpu_level,
	input wire logic core_ack,
	output logic core_irq_ff,
	output logic [6:0] core_vec_num_ff,
	output logic [23:0] core_vec_addr_ff,
	output logic [23:0] core_handler_ff,
	output logic [3:0] core_level_ff,
	output logic boot_go_ff,
	output logic [23:0] boot_pc_ff,
	output logic irq_ff
);
	// ==========================================================
	// Bus slave
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic rd_pend_ff;
	logic [7:0] rd_addr_ff;
	logic a_valid;
	logic a_hit;
	logic [7:0] a_ofs;
	logic [31:0] rd_word;

	assign a_valid = hsel && hready && htrans[1];
	assign a_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
	assign a_ofs = haddr[7:0];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b0;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			wr_pend_ff <= a_valid && hwrite && a_hit;
			rd_pend_ff <= a_valid && !hwrite;
			if (a_valid) begin
				wr_addr_ff <= a_ofs;
				rd_addr_ff <= a_ofs;
			end
			if (a_valid && !hwrite) begin
				hrdata_ff <= a_hit ? rd_word : 32'h00000000;
			end
		end
	end

	function automatic logic wr_to(input logic [7:0] ofs);
		wr_to = wr_pend_ff && (wr_addr_ff == ofs);
	endfunction : wr_to

	// ==========================================================
	// Control, table index and sticky events
	logic alt_ff;
	logic [5:0] vec_idx_ff;
	logic [IVPU_EV_N-1:0] stat_ff;
	logic [IVPU_EV_N-1:0] mask_ff;
	logic [IVPU_EV_N-1:0] ev;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alt_ff <= 1'b0;
			vec_idx_ff <= 6'h00;
			mask_ff <= '0;
		end else begin
			if (wr_to(IVPU_OFS_CTRL2)) begin
				alt_ff <= hwdata[IVPU_ALT_BIT];
			end
			if (wr_to(IVPU_OFS_VEC_IDX)) begin
				vec_idx_ff <= hwdata[5:0];
			end
			if (wr_to(IVPU_OFS_IRQ_MASK)) begin
				mask_ff <= hwdata[IVPU_EV_N-1:0];
			end
		end
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			if (wr_to(IVPU_OFS_IRQ_STAT)) begin
				stat_ff <= (stat_ff & ~hwdata[IVPU_EV_N-1:0]) | ev;
			end else begin
				stat_ff <= stat_ff | ev;
			end
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// ==========================================================
	// Vector tables, primary then alternate in one array
	logic [23:0] tbl_ff [IVPU_TBL_WORDS];
	logic idx_ok;
	int unsigned idx_word;

	assign idx_ok = (32'(vec_idx_ff[4:0]) < IVPU_ENTRIES);
	assign idx_word = (vec_idx_ff[5] ? IVPU_ENTRIES : 0) + 32'(vec_idx_ff[4:0]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < IVPU_TBL_WORDS; k++) begin
				tbl_ff[k] <= 24'h000000;
			end
		end else if (wr_to(IVPU_OFS_VEC_DATA) && idx_ok) begin
			tbl_ff[idx_word] <= hwdata[23:0];
		end
	end

	// ==========================================================
	// Per-source flags and priorities
	logic [IVPU_SRC_N-1:0] flag_ff;
	logic [2:0] prio_ff [IVPU_SRC_N];
	logic [IVPU_SRC_N-1:0] live;
	logic [IVPU_SRC_N-1:0] ack_clr;
	logic [IVPU_SRC_N-1:0] dis_hit;
	logic [4:0] trap_pend_ff;
	logic cur_trap_ff;
	logic [4:0] cur_idx_ff;

	generate
		for (genvar i = 0; i < IVPU_SRC_N; i++) begin : g_src
			logic wr_flag;
			logic wr_prio;
			logic [7:0] prio_ofs;

			assign live[i] = !(IVPU_IS_CAN[i] && !HAS_CAN);
			assign ack_clr[i] = core_irq_ff && core_ack && !cur_trap_ff && (32'(cur_idx_ff) == i);
			assign dis_hit[i] = src_req[i] && live[i] && (prio_ff[i] == IVPU_PRIO_OFF);
			assign wr_flag = wr_pend_ff && (wr_addr_ff == (IVPU_FLAG_IN_F2[i] ? IVPU_OFS_FLAGS2 : IVPU_OFS_FLAGS_AUX));
			assign prio_ofs = (IVPU_PRIO_REG[i] == 0) ? IVPU_OFS_PRIO_CN :
				(IVPU_PRIO_REG[i] == 1) ? IVPU_OFS_PRIO_ENC : IVPU_OFS_PRIO_GRP2;
			assign wr_prio = wr_pend_ff && (wr_addr_ff == prio_ofs);

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					flag_ff[i] <= 1'b0;
				end else if (!live[i]) begin
					flag_ff[i] <= 1'b0;
				end else if (src_req[i]) begin
					flag_ff[i] <= 1'b1;
				end else if (ack_clr[i]) begin
					flag_ff[i] <= 1'b0;
				end else if (wr_flag) begin
					flag_ff[i] <= hwdata[IVPU_FLAG_POS[i]];
				end
			end

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					prio_ff[i] <= IVPU_PRIO_RST;
				end else if (wr_prio) begin
					prio_ff[i] <= hwdata[IVPU_PRIO_LSB[i] +: 3];
				end
			end

			chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
				src_req[i] && live[i] |=> flag_ff[i])
				else $error("request flag not set after source request");
		end
	endgenerate

	// ==========================================================
	// Read assembly; unused bit positions stay zero
	logic [15:0] f2_word;
	logic [15:0] aux_word;
	logic [15:0] pcn_word;
	logic [15:0] penc_word;
	logic [31:0] pgrp_word;

	always_comb begin
		f2_word = 16'h0000;
		aux_word = 16'h0000;
		pcn_word = 16'h0000;
		penc_word = 16'h0000;
		pgrp_word = 32'h00000000;
		for (int i = 0; i < IVPU_SRC_N; i++) begin
			if (IVPU_FLAG_IN_F2[i]) begin
				f2_word[IVPU_FLAG_POS[i]] = flag_ff[i];
			end else begin
				aux_word[IVPU_FLAG_POS[i]] = flag_ff[i];
			end
			case (IVPU_PRIO_REG[i])
				0: pcn_word[IVPU_PRIO_LSB[i] +: 3] = prio_ff[i];
				1: penc_word[IVPU_PRIO_LSB[i] +: 3] = prio_ff[i];
				default: pgrp_word[IVPU_PRIO_LSB[i] +: 3] = prio_ff[i];
			endcase
		end
	end

	always_comb begin
		case (a_ofs)
			IVPU_OFS_CTRL2: rd_word = {16'h0000, alt_ff, 15'h0000};
			IVPU_OFS_FLAGS2: rd_word = {16'h0000, f2_word & IVPU_FLAGS2_MASK};
			IVPU_OFS_PRIO_CN: rd_word = {16'h0000, pcn_word & IVPU_PRIO_CN_MASK};
			IVPU_OFS_PRIO_ENC: rd_word = {16'h0000, penc_word & IVPU_PRIO_ENC_MASK};
			IVPU_OFS_PRIO_GRP2: rd_word = pgrp_word & IVPU_PRIO_GRP2_MASK;
			IVPU_OFS_FLAGS_AUX: rd_word = {16'h0000, aux_word & IVPU_AUX_MASK};
			IVPU_OFS_VEC_IDX: rd_word = {26'h0000000, vec_idx_ff};
			IVPU_OFS_VEC_DATA: rd_word = idx_ok ? {8'h00, tbl_ff[idx_word]} : 32'h00000000;
			IVPU_OFS_IRQ_STAT: rd_word = {29'h00000000, stat_ff};
			IVPU_OFS_IRQ_MASK: rd_word = {29'h00000000, mask_ff};
			IVPU_OFS_CORE_STAT: rd_word = {19'h00000, core_level_ff, core_vec_num_ff, 1'b0, core_irq_ff};
			default: rd_word = 32'h00000000;
		endcase
	end

	// ==========================================================
	// Arbiter: traps first, then level, then natural order
	logic best_v;
	logic best_trap;
	logic [4:0] best_idx;
	logic [3:0] best_lvl;
	logic [6:0] best_num;
	logic [4:0] best_entry;
	logic [23:0] best_handler;

	always_comb begin
		best_v = 1'b0;
		best_trap = 1'b0;
		best_idx = 5'h00;
		best_lvl = 4'h0;
		for (int i = IVPU_SRC_N - 1; i >= 0; i--) begin
			if (flag_ff[i] && live[i] && (prio_ff[i] != IVPU_PRIO_OFF)
				&& ({1'b0, prio_ff[i]} > cpu_level) && (!best_v || {1'b0, prio_ff[i]} >= best_lvl)) begin
				best_v = 1'b1;
				best_idx = 5'(i);
				best_lvl = {1'b0, prio_ff[i]};
			end
		end
		for (int t = IVPU_TRAP_N - 1; t >= 0; t--) begin
			if (trap_pend_ff[t]) begin
				best_v = 1'b1;
				best_trap = 1'b1;
				best_idx = 5'(t);
				best_lvl = IVPU_TRAP_LEVEL;
			end
		end
		best_num = best_trap ? {2'h0, best_idx} : IVPU_TRAP_SLOTS + {2'h0, best_idx};
		best_entry = best_trap ? best_idx : 5'(IVPU_TRAP_N) + best_idx;
		best_handler = tbl_ff[(alt_ff ? IVPU_ENTRIES : 0) + 32'(best_entry)];
	end

	// ==========================================================
	// Trap pending latches and core handshake
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trap_pend_ff <= 5'h00;
		end else begin
			for (int t = 0; t < IVPU_TRAP_N; t++) begin
				if (trap_req[t]) begin
					trap_pend_ff[t] <= 1'b1;
				end else if (core_irq_ff && core_ack && cur_trap_ff && (32'(cur_idx_ff) == t)) begin
					trap_pend_ff[t] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_irq_ff <= 1'b0;
			core_vec_num_ff <= 7'h00;
			core_vec_addr_ff <= 24'h000000;
			core_handler_ff <= 24'h000000;
			core_level_ff <= 4'h0;
			cur_trap_ff <= 1'b0;
			cur_idx_ff <= 5'h00;
		end else if (core_irq_ff) begin
			if (core_ack) begin
				core_irq_ff <= 1'b0;
			end
		end else if (best_v) begin
			core_irq_ff <= 1'b1;
			core_vec_num_ff <= best_num;
			core_vec_addr_ff <= IVPU_IVT_BASE + (alt_ff ? IVPU_IVT_LEN : 24'h000000) + {17'h00000, best_num};
			core_handler_ff <= best_handler;
			core_level_ff <= best_lvl;
			cur_trap_ff <= best_trap;
			cur_idx_ff <= best_idx;
		end
	end

	assign ev[IVPU_EV_TRAP] = |trap_req;
	assign ev[IVPU_EV_ACK] = core_irq_ff && core_ack;
	assign ev[IVPU_EV_DIS] = |dis_hit;

	// ==========================================================
	// Boot fetch after reset
	logic started_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			started_ff <= 1'b0;
			boot_go_ff <= 1'b0;
			boot_pc_ff <= IVPU_BOOT_ADDR;
		end else begin
			started_ff <= 1'b1;
			boot_go_ff <= !started_ff;
			boot_pc_ff <= IVPU_BOOT_ADDR;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence seq_taken;
		core_irq_ff && core_ack;
	endsequence

	sequence seq_released;
		!core_irq_ff ##1 1'b1;
	endsequence

	chk_vec_location: assert property ($rose(core_irq_ff) |->
		core_vec_addr_ff == IVPU_IVT_BASE + ($past(alt_ff) ? IVPU_IVT_LEN : 24'h000000)
		+ {17'h00000, core_vec_num_ff})
		else $error("vector location does not match table base");

	chk_trap_first: assert property ($rose(core_irq_ff) && (|$past(trap_pend_ff)) |->
		core_vec_num_ff < IVPU_TRAP_SLOTS && core_level_ff == IVPU_TRAP_LEVEL)
		else $error("trap did not win arbitration");

	chk_level_valid: assert property ($rose(core_irq_ff) && core_vec_num_ff >= IVPU_TRAP_SLOTS |->
		core_level_ff != 4'h0 && core_level_ff > $past(cpu_level))
		else $error("disabled or masked source delivered");

	chk_ack_release: assert property (seq_taken |=> seq_released)
		else $error("request not released after acknowledge");

	chk_prio_reset: assert property ($rose(started_ff) |->
		prio_ff[0] == IVPU_PRIO_RST && prio_ff[12] == IVPU_PRIO_RST)
		else $error("priority field not level four after reset");

	chk_boot_fetch: assert property ($rose(started_ff) |->
		boot_go_ff && boot_pc_ff == IVPU_BOOT_ADDR ##1 !boot_go_ff)
		else $error("boot fetch pulse wrong");

	chk_flags_zero: assert property (rd_pend_ff && rd_addr_ff == IVPU_OFS_FLAGS2 |->
		(hrdata_ff[15:0] & ~IVPU_FLAGS2_MASK) == 16'h0000 && hrdata_ff[31:16] == 16'h0000)
		else $error("unimplemented flag bits read nonzero");

	chk_can_off: assert property (!HAS_CAN |-> !flag_ff[6] && !flag_ff[7])
		else $error("CAN flag set on variant without CAN");

	chk_event_sticky: assert property (ev[IVPU_EV_ACK] ##1 mask_ff[IVPU_EV_ACK] |-> stat_ff[IVPU_EV_ACK] ##1 irq_ff)
		else $error("acknowledge event not captured");
endmodule : ivpu_top
`default_nettype wire

// File: testbench/ivpu_core_model.sv
// CPU core partner model that takes presented interrupts
`timescale 1ns/10ps
`default_nettype none
module ivpu_core_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] delay,
	input wire logic core_irq_ff,
	input wire logic [6:0] core_vec_num_ff,
	input wire logic [23:0] core_vec_addr_ff,
	input wire logic [23:0] core_handler_ff,
	input wire logic [3:0] core_level_ff,
	output logic core_ack_ff,
	output logic [7:0] taken_ff,
	output logic [6:0] num_ff,
	output logic [23:0] addr_ff,
	output logic [23:0] handler_ff,
	output logic [3:0] level_ff
);
	logic [3:0] wait_ff;
	// ==========================================================
	// Acknowledge after a set wait, capture the vector
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_ack_ff <= 1'b0;
			wait_ff <= 4'h0;
			taken_ff <= 8'h00;
			num_ff <= 7'h00;
			addr_ff <= 24'h000000;
			handler_ff <= 24'h000000;
			level_ff <= 4'h0;
		end else if (core_ack_ff && core_irq_ff) begin
			core_ack_ff <= 1'b0;
			wait_ff <= 4'h0;
			taken_ff <= taken_ff + 8'h01;
			num_ff <= core_vec_num_ff;
			addr_ff <= core_vec_addr_ff;
			handler_ff <= core_handler_ff;
			level_ff <= core_level_ff;
		end else if (core_irq_ff) begin
			if (wait_ff >= delay) begin
				core_ack_ff <= 1'b1;
			end else begin
				wait_ff <= wait_ff + 4'h1;
			end
		end
	end
endmodule : ivpu_core_model
`default_nettype wire

// File: testbench/ivpu_top_tb.sv
// Self-checking bench for the interrupt vector and priority unit
`timescale 1ns/10ps
`default_nettype none
module ivpu_top_tb;
	import ivpu_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [12:0] src_req = 13'h0000;
	logic [4:0] trap_req = 5'h00;
	logic [3:0] cpu_level = 4'h7;
	logic [3:0] delay = 4'h0;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic core_ack, core_irq_ff, boot_go_ff, irq_ff;
	logic [6:0] core_vec_num_ff, num_ff;
	logic [23:0] core_vec_addr_ff, core_handler_ff, boot_pc_ff, addr_ff, handler_ff;
	logic [3:0] core_level_ff, level_ff;
	logic [7:0] taken_ff;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	ivpu_top ivpu_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout_ff), .hwdata(hwdata), .hrdata_ff(hrdata_ff),
		.hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .src_req(src_req), .trap_req(trap_req),
		.cpu_level(cpu_level), .core_ack(core_ack), .core_irq_ff(core_irq_ff),
		.core_vec_num_ff(core_vec_num_ff), .core_vec_addr_ff(core_vec_addr_ff),
		.core_handler_ff(core_handler_ff), .core_level_ff(core_level_ff), .boot_go_ff(boot_go_ff),
		.boot_pc_ff(boot_pc_ff), .irq_ff(irq_ff));
	ivpu_core_model ivpu_core_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .delay(delay),
		.core_irq_ff(core_irq_ff), .core_vec_num_ff(core_vec_num_ff), .core_vec_addr_ff(core_vec_addr_ff),
		.core_handler_ff(core_handler_ff), .core_level_ff(core_level_ff), .core_ack_ff(core_ack),
		.taken_ff(taken_ff), .num_ff(num_ff), .addr_ff(addr_ff), .handler_ff(handler_ff), .level_ff(level_ff));
	// ==========================================================
	// Compare, close and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic ahb(input logic [7:0] ofs, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h000000, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clk_sys); while (hreadyout_ff !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wdata : 32'h00000000;
		do @(posedge clk_sys); while (hreadyout_ff !== 1'b1);
		rdata = hrdata_ff;
	endtask : ahb
	task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
		logic [31:0] unused;
		ahb(ofs, 1'b1, data, unused);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] seen;
		ahb(ofs, 1'b0, 32'h00000000, seen);
		check(seen, exp);
	endtask : rd
	task automatic pulse(input logic [12:0] s, input logic [4:0] t);
		@(posedge clk_sys);
		src_req <= s;
		trap_req <= t;
		@(posedge clk_sys);
		src_req <= 13'h0000;
		trap_req <= 5'h00;
	endtask : pulse
	task automatic wait_taken(input logic [7:0] n);
		for (int i = 0; i < 60 && taken_ff !== n; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check(taken_ff, n);
	endtask : wait_taken
	task automatic chk_vec(input logic [6:0] n, input logic [23:0] a, input logic [23:0] h, input logic [3:0] l);
		check(num_ff, n);
		check(addr_ff, a);
		check(handler_ff, h);
		check(level_ff, l);
	endtask : chk_vec
	task automatic irq_is(input logic v);
		@(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		check(irq_ff, v);
	endtask : irq_is
	// ==========================================================
	// Timeout
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(boot_go_ff, 1'b1);
		check(boot_pc_ff, IVPU_BOOT_ADDR);
		@(posedge clk_sys);
		#1;
		check(boot_go_ff, 1'b0);
		rd(IVPU_OFS_CTRL2, 32'h00000000);
		rd(IVPU_OFS_FLAGS2, 32'h00000000);
		rd(IVPU_OFS_PRIO_CN, 32'h00004444);
		rd(IVPU_OFS_PRIO_ENC, 32'h00000440);
		rd(IVPU_OFS_PRIO_GRP2, 32'h04444444);
		wr(IVPU_OFS_FLAGS2, 32'h0000FFFF);
		rd(IVPU_OFS_FLAGS2, 32'h0000601F);
		wr(IVPU_OFS_FLAGS2, 32'h00000000);
		rd(IVPU_OFS_FLAGS2, 32'h00000000);
		wr(IVPU_OFS_PRIO_CN, 32'h0000FFFF);
		rd(IVPU_OFS_PRIO_CN, 32'h00007777);
		wr(IVPU_OFS_PRIO_CN, 32'h00004444);
		wr(IVPU_OFS_PRIO_ENC, 32'h0000FFFF);
		rd(IVPU_OFS_PRIO_ENC, 32'h00000770);
		wr(IVPU_OFS_PRIO_ENC, 32'h00000440);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h00000000);
		wr(IVPU_OFS_VEC_IDX, 32'h00000000);
		wr(IVPU_OFS_VEC_DATA, 32'h00000ABC);
		wr(IVPU_OFS_VEC_IDX, 32'h0000000E);
		wr(IVPU_OFS_VEC_DATA, 32'h00123456);
		wr(IVPU_OFS_VEC_IDX, 32'h0000002E);
		wr(IVPU_OFS_VEC_DATA, 32'h00654321);
		rd(IVPU_OFS_VEC_IDX, 32'h0000002E);
		rd(IVPU_OFS_VEC_DATA, 32'h00654321);
		pulse(13'h0000, 5'h01);
		wait_taken(8'h01);
		chk_vec(7'h00, IVPU_IVT_BASE, 24'h000ABC, IVPU_TRAP_LEVEL);
		irq_is(1'b0);
		rd(IVPU_OFS_IRQ_STAT, 32'h00000003);
		wr(IVPU_OFS_IRQ_MASK, 32'h00000003);
		rd(IVPU_OFS_IRQ_MASK, 32'h00000003);
		irq_is(1'b1);
		wr(IVPU_OFS_IRQ_STAT, 32'h00000003);
		irq_is(1'b0);
		cpu_level <= 4'h0;
		pulse(13'h0200, 5'h00);
		wait_taken(8'h02);
		chk_vec(7'h11, 24'h000015, 24'h123456, 4'h4);
		rd(IVPU_OFS_FLAGS2, 32'h00000000);
		wr(IVPU_OFS_CTRL2, 32'h00008000);
		pulse(13'h0200, 5'h00);
		wait_taken(8'h03);
		chk_vec(7'h11, 24'h000093, 24'h654321, 4'h4);
		wr(IVPU_OFS_CTRL2, 32'h00000000);
		delay <= 4'h3;
		pulse(13'h0500, 5'h00);
		wait_taken(8'h04);
		check(num_ff, 7'h10);
		wait_taken(8'h05);
		check(num_ff, 7'h12);
		wr(IVPU_OFS_PRIO_GRP2, 32'h06444444);
		rd(IVPU_OFS_PRIO_GRP2, 32'h06444444);
		pulse(13'h0500, 5'h00);
		wait_taken(8'h06);
		chk_vec(7'h12, 24'h000016, 24'h000000, 4'h6);
		wait_taken(8'h07);
		check(num_ff, 7'h10);
		wr(IVPU_OFS_PRIO_CN, 32'h00000444);
		pulse(13'h0001, 5'h00);
		repeat (10) @(posedge clk_sys);
		#1;
		check(taken_ff, 8'h07);
		rd(IVPU_OFS_IRQ_STAT, 32'h00000006);
		rd(IVPU_OFS_CORE_STAT, 32'h00000840);
		rd(IVPU_OFS_FLAGS_AUX, 32'h00000001);
		check(hresp_ff, 1'b0);
		end_sim();
	end
endmodule : ivpu_top_tb
`default_nettype wire
